// ### hw/twp_cfg_if.sv
`timescale 1ns/1ps
// ==========================================================================
// Latch register file access between load logic and storage
// ==========================================================================
interface twp_cfg_if;
	logic                           wr_en;
	logic [twp_pkg::SEL_BITS-1:0]   wr_sel;
	logic [twp_pkg::DATA_BITS-1:0]  wr_data;
	logic [twp_pkg::SEL_BITS-1:0]   rd_sel;
	logic [twp_pkg::DATA_BITS-1:0]  rd_data;

	modport ctrl (
		output wr_en,
		output wr_sel,
		output wr_data,
		output rd_sel,
		input  rd_data
	);

	modport store (
		input  wr_en,
		input  wr_sel,
		input  wr_data,
		input  rd_sel,
		output rd_data
	);
endinterface

// ### hw/twp_latch_mem.sv
`timescale 1ns/1ps
// ==========================================================================
// Latch register storage, registered read
// ==========================================================================
module twp_latch_mem (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Access port
	twp_cfg_if.store cfg
);

	logic [twp_pkg::DATA_BITS-1:0] mem [twp_pkg::NUM_REGS];

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < twp_pkg::NUM_REGS; i++) begin
				mem[i] <= twp_pkg::DATA_RST;
			end
		end else if (cfg.wr_en) begin
			mem[cfg.wr_sel] <= cfg.wr_data;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cfg.rd_data <= twp_pkg::DATA_RST;
		end else begin
			cfg.rd_data <= mem[cfg.rd_sel];
		end
	end

endmodule

// ### hw/twp_pkg.sv
// ==========================================================================
// Constants for the three-wire programming port
// ==========================================================================
package twp_pkg;

	// Word layout: data field above, register-select field in the last bits
	localparam int WORD_BITS = 24;
	localparam int SEL_BITS  = 4;
	localparam int DATA_BITS = WORD_BITS - SEL_BITS;
	localparam int NUM_REGS  = 16;
	localparam int SEL_LSB   = 0;
	localparam int DATA_LSB  = SEL_BITS;

	// Register selects with a side effect
	localparam logic [SEL_BITS-1:0] REG_ZERO_SEL = 4'h0;
	localparam logic [SEL_BITS-1:0] PWR_REG_SEL  = 4'h1;

	// Power-control field inside the power register data
	localparam int PWR_LSB  = 0;
	localparam int PWR_BITS = 4;

	// Serial edge counter crossing to the system clock
	localparam int CNT_BITS  = 8;
	localparam int SYNC_DEPTH = 3;

	// Values after reset
	localparam logic [WORD_BITS-1:0] SHIFT_RST = 24'h00_0000;
	localparam logic [DATA_BITS-1:0] DATA_RST  = 20'h0_0000;
	localparam logic [PWR_BITS-1:0]  PWR_RST   = 4'h0;
	localparam logic [CNT_BITS-1:0]  CNT_RST   = 8'h00;
	localparam logic [15:0]          LOADS_RST = 16'h0000;

	// Word length expected between two loads
	localparam logic [CNT_BITS-1:0] WORD_EDGES = 8'h18;

	// Load sequencer states
	typedef enum logic [3:0] {
		TWP_IDLE  = 4'b0001,
		TWP_CAPT  = 4'b0010,
		TWP_WRITE = 4'b0100,
		TWP_HOLD  = 4'b1000
	} twp_state_e;

endpackage

// ### hw/twp_program_port.sv
`timescale 1ns/1ps
module twp_program_port (
	// System clock and reset
	input  wire logic                           clk_sys,
	input  wire logic                           arst_n,
	// Serial programming pins
	input  wire logic                           prog_clk,
	input  wire logic                           prog_data,
	input  wire logic                           latch_load_strobe,
	input  wire logic                           chip_enable,
	// Latch register readback
	input  wire logic [twp_pkg::SEL_BITS-1:0]   cfg_rd_sel,
	output logic      [twp_pkg::DATA_BITS-1:0]  cfg_rd_data,
	// Power control
	output logic      [twp_pkg::PWR_BITS-1:0]   sect_pwr_en,
	output logic                                powered,
	output logic                                relock_pending,
	output logic                                relock_req,
	// Load status
	output logic                                load_done,
	output logic      [twp_pkg::SEL_BITS-1:0]   load_sel,
	output logic                                word_len_err,
	output logic      [15:0]                    load_count
);

	// ======================================================================
	// Helpers
	// ======================================================================
	function automatic logic [twp_pkg::SEL_BITS-1:0] sel_of(
		input logic [twp_pkg::WORD_BITS-1:0] w
	);
		sel_of = w[twp_pkg::SEL_LSB +: twp_pkg::SEL_BITS];
	endfunction

	function automatic logic [twp_pkg::DATA_BITS-1:0] data_of(
		input logic [twp_pkg::WORD_BITS-1:0] w
	);
		data_of = w[twp_pkg::DATA_LSB +: twp_pkg::DATA_BITS];
	endfunction

	function automatic logic [twp_pkg::CNT_BITS-1:0] gray_to_bin(
		input logic [twp_pkg::CNT_BITS-1:0] g
	);
		logic [twp_pkg::CNT_BITS-1:0] b;
		b = g;
		for (int i = twp_pkg::CNT_BITS - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		gray_to_bin = b;
	endfunction

	// ======================================================================
	// Serial clock domain: shift register and edge counter
	// ======================================================================
	logic [twp_pkg::WORD_BITS-1:0] shift_q;
	logic [twp_pkg::CNT_BITS-1:0]  edge_bin;
	logic [twp_pkg::CNT_BITS-1:0]  edge_gray;
	logic [twp_pkg::CNT_BITS-1:0]  next_edge_bin;

	assign next_edge_bin = edge_bin + 8'h01;

	// New bit enters at the bottom, so the first bit ends up on top
	always_ff @(posedge prog_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_q <= twp_pkg::SHIFT_RST;
		end else begin
			shift_q <= {shift_q[twp_pkg::WORD_BITS-2:0], prog_data};
		end
	end

	always_ff @(posedge prog_clk or negedge arst_n) begin
		if (!arst_n) begin
			edge_bin  <= twp_pkg::CNT_RST;
			edge_gray <= twp_pkg::CNT_RST;
		end else begin
			edge_bin  <= next_edge_bin;
			edge_gray <= next_edge_bin ^ (next_edge_bin >> 1);
		end
	end

	// ======================================================================
	// Pin synchronisers into the system clock
	// ======================================================================
	// Index 0: load strobe, index 1: chip enable
	localparam int NUM_PINS = 2;

	logic [NUM_PINS-1:0] pin_raw;
	logic [NUM_PINS-1:0] pin_lvl;

	assign pin_raw = {chip_enable, latch_load_strobe};

	generate
		for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
			logic s1;
			logic s2;
			logic s3;

			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
				end else begin
					s1 <= pin_raw[p];
					s2 <= s1;
					s3 <= s2;
				end
			end

			// Level moves only once the last two stages agree
			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					pin_lvl[p] <= 1'b0;
				end else if (s2 == s3) begin
					pin_lvl[p] <= s3;
				end
			end
		end
	endgenerate

	logic strobe_lvl;
	logic strobe_prev;
	logic strobe_rise;
	logic ce_prev;
	logic ce_rise;

	assign strobe_lvl  = pin_lvl[0];
	assign strobe_rise = strobe_lvl & ~strobe_prev;
	assign ce_rise     = pin_lvl[1] & ~ce_prev;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			strobe_prev <= 1'b0;
			ce_prev     <= 1'b0;
		end else begin
			strobe_prev <= strobe_lvl;
			ce_prev     <= pin_lvl[1];
		end
	end

	// ======================================================================
	// Edge counter crossing, gray coded
	// ======================================================================
	logic [twp_pkg::CNT_BITS-1:0] gray_s1;
	logic [twp_pkg::CNT_BITS-1:0] gray_s2;
	logic [twp_pkg::CNT_BITS-1:0] gray_s3;
	logic [twp_pkg::CNT_BITS-1:0] edge_sys;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			gray_s1 <= twp_pkg::CNT_RST;
			gray_s2 <= twp_pkg::CNT_RST;
			gray_s3 <= twp_pkg::CNT_RST;
		end else begin
			gray_s1 <= edge_gray;
			gray_s2 <= gray_s1;
			gray_s3 <= gray_s2;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			edge_sys <= twp_pkg::CNT_RST;
		end else if (gray_s2 == gray_s3) begin
			edge_sys <= gray_to_bin(gray_s3);
		end
	end

	// ======================================================================
	// Load sequencer
	// ======================================================================
	twp_pkg::twp_state_e state;
	twp_pkg::twp_state_e next_state;

	always_comb begin
		next_state = state;
		case (state)
			twp_pkg::TWP_IDLE: begin
				if (strobe_rise) begin
					next_state = twp_pkg::TWP_CAPT;
				end
			end
			twp_pkg::TWP_CAPT: begin
				next_state = twp_pkg::TWP_WRITE;
			end
			twp_pkg::TWP_WRITE: begin
				next_state = twp_pkg::TWP_HOLD;
			end
			twp_pkg::TWP_HOLD: begin
				if (!strobe_lvl) begin
					next_state = twp_pkg::TWP_IDLE;
				end
			end
			default: begin
				next_state = twp_pkg::TWP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= twp_pkg::TWP_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ======================================================================
	// Word capture
	// ======================================================================
	// Serial clock is idle once the strobe is up, so the word is stable here
	logic [twp_pkg::WORD_BITS-1:0] word_q;
	logic [twp_pkg::CNT_BITS-1:0]  edge_at_load;
	logic [twp_pkg::CNT_BITS-1:0]  word_edges;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			word_q <= twp_pkg::SHIFT_RST;
		end else if (state == twp_pkg::TWP_CAPT) begin
			word_q <= shift_q;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			word_edges   <= twp_pkg::CNT_RST;
			edge_at_load <= twp_pkg::CNT_RST;
		end else if (state == twp_pkg::TWP_CAPT) begin
			word_edges   <= edge_sys - edge_at_load;
			edge_at_load <= edge_sys;
		end
	end

	// ======================================================================
	// Latch register storage
	// ======================================================================
	twp_cfg_if cfg ();

	// Writes happen only in the one WRITE cycle, two cycles after strobe_rise
	assign cfg.wr_en   = (state == twp_pkg::TWP_WRITE);
	assign cfg.wr_sel  = sel_of(word_q);
	assign cfg.wr_data = data_of(word_q);
	assign cfg.rd_sel  = cfg_rd_sel;
	assign cfg_rd_data = cfg.rd_data;

	twp_latch_mem u_mem (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.cfg     (cfg.store)
	);

	// ======================================================================
	// Load status
	// ======================================================================
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			load_done    <= 1'b0;
			load_sel     <= twp_pkg::REG_ZERO_SEL;
			word_len_err <= 1'b0;
			load_count   <= twp_pkg::LOADS_RST;
		end else begin
			load_done <= cfg.wr_en;
			if (cfg.wr_en) begin
				load_sel     <= cfg.wr_sel;
				word_len_err <= (word_edges != twp_pkg::WORD_EDGES);
				load_count   <= load_count + 16'h0001;
			end
		end
	end

	// ======================================================================
	// Power control
	// ======================================================================
	logic [twp_pkg::PWR_BITS-1:0] pwr_bits;
	logic                         zero_wr;

	assign zero_wr = cfg.wr_en && (cfg.wr_sel == twp_pkg::REG_ZERO_SEL);

	// Power bits follow loads regardless of chip enable
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pwr_bits <= twp_pkg::PWR_RST;
		end else if (cfg.wr_en && (cfg.wr_sel == twp_pkg::PWR_REG_SEL)) begin
			pwr_bits <= cfg.wr_data[twp_pkg::PWR_LSB +: twp_pkg::PWR_BITS];
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			powered     <= 1'b0;
			sect_pwr_en <= twp_pkg::PWR_RST;
		end else begin
			powered     <= pin_lvl[1];
			sect_pwr_en <= pin_lvl[1] ? pwr_bits : twp_pkg::PWR_RST;
		end
	end

	// Loop needs a fresh register zero after each power-up; set wins
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			relock_pending <= 1'b0;
			relock_req     <= 1'b0;
		end else begin
			relock_req <= zero_wr & pin_lvl[1];
			if (ce_rise) begin
				relock_pending <= 1'b1;
			end else if (zero_wr) begin
				relock_pending <= 1'b0;
			end
		end
	end

endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
// ==========================================================
// Bench top
module tb;
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic        chip_enable = 1'b0;
	logic [3:0]  cfg_rd_sel = 4'h0;
	logic        prog_clk, prog_data, latch_load_strobe, rq;
	logic        powered, relock_pending, relock_req, load_done, word_len_err;
	logic [3:0]  sect_pwr_en, load_sel;
	logic [19:0] cfg_rd_data;
	logic [15:0] load_count;
	int          fail_count = 0;
	int          cmp_count = 0;

	always #25 clk_sys = ~clk_sys;

	twp_host host (.clk_sys(clk_sys), .prog_clk(prog_clk), .prog_data(prog_data),
		.latch_load_strobe(latch_load_strobe));

	twp_program_port dut (.clk_sys(clk_sys), .arst_n(arst_n), .prog_clk(prog_clk),
		.prog_data(prog_data), .latch_load_strobe(latch_load_strobe),
		.chip_enable(chip_enable), .cfg_rd_sel(cfg_rd_sel), .cfg_rd_data(cfg_rd_data),
		.sect_pwr_en(sect_pwr_en), .powered(powered), .relock_pending(relock_pending),
		.relock_req(relock_req), .load_done(load_done), .load_sel(load_sel),
		.word_len_err(word_len_err), .load_count(load_count));

	task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict;
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic load(input logic [23:0] w, input int n);
		host.shift(w, n);
		host.strobe(1'b1);
		for (int i = 0; i < 20 && load_done !== 1'b1; i++) @(negedge clk_sys);
		check("load_done", 20'h0_0001, load_done);
		rq = relock_req;
		if (n == 24) check("load_sel", w[3:0], load_sel);
		repeat (4) @(negedge clk_sys);
		host.strobe(1'b0);
		repeat (6) @(negedge clk_sys);
	endtask

	task automatic rd(input logic [3:0] s, input logic [19:0] exp);
		@(negedge clk_sys) cfg_rd_sel = s;
		@(negedge clk_sys) check("cfg_rd_data", exp, cfg_rd_data);
	endtask

	task automatic t_store_off;
		load(24'h12_3452, 24);
		load(24'hAB_CDE3, 24);
		load(24'h80_000F, 24);
		rd(4'h2, 20'h1_2345);
		rd(4'h3, 20'hA_BCDE);
		rd(4'hF, 20'h8_0000);
		check("powered", 20'h0_0000, powered);
	endtask

	task automatic t_no_strobe;
		host.shift(24'h05_5552, 24);
		repeat (10) @(negedge clk_sys);
		rd(4'h2, 20'h1_2345);
		check("load_count", 20'h0_0003, load_count);
	endtask

	task automatic t_power;
		load(24'h00_0010, 24);
		check("relock_req", 20'h0_0000, rq);
		check("relock_pending", 20'h0_0000, relock_pending);
		rd(4'h0, 20'h0_0001);
		load(24'h00_0051, 24);
		check("sect_pwr_en", 20'h0_0000, sect_pwr_en);
		chip_enable = 1'b1;
		repeat (8) @(negedge clk_sys);
		check("powered", 20'h0_0001, powered);
		check("sect_pwr_en", 20'h0_0005, sect_pwr_en);
		check("relock_pending", 20'h0_0001, relock_pending);
		load(24'h06_7890, 24);
		check("relock_req", 20'h0_0001, rq);
		check("relock_pending", 20'h0_0000, relock_pending);
		rd(4'h0, 20'h0_6789);
		chip_enable = 1'b0;
		repeat (8) @(negedge clk_sys);
		check("sect_pwr_en", 20'h0_0000, sect_pwr_en);
	endtask

	task automatic t_short;
		load(24'h09_9993, 20);
		check("word_len_err", 20'h0_0001, word_len_err);
		check("load_sel", 20'h0_0003, load_sel);
		rd(4'h3, 20'h0_9999);
		load(24'h44_4444, 24);
		check("word_len_err", 20'h0_0000, word_len_err);
		check("load_count", 20'h0_0008, load_count);
	endtask

	initial begin
		#500_000;
		fail_count++;
		give_verdict();
	end

	initial begin
		repeat (5) @(negedge clk_sys);
		arst_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		check("load_count", 20'h0_0000, load_count);
		check("relock_pending", 20'h0_0000, relock_pending);
		t_store_off();
		t_no_strobe();
		t_power();
		t_short();
		give_verdict();
	end
endmodule

bind twp_program_port twp_chk chk (.clk_sys(clk_sys), .arst_n(arst_n),
	.latch_load_strobe(latch_load_strobe), .sect_pwr_en(sect_pwr_en), .powered(powered),
	.relock_pending(relock_pending), .relock_req(relock_req), .load_done(load_done),
	.load_sel(load_sel), .load_count(load_count));

// ### tb/twp_chk.sv
`timescale 1ns/1ps
// ==========================================================
// Port checks
module twp_chk (
	input wire logic        clk_sys,
	input wire logic        arst_n,
	input wire logic        latch_load_strobe,
	input wire logic [3:0]  sect_pwr_en,
	input wire logic        powered,
	input wire logic        relock_pending,
	input wire logic        relock_req,
	input wire logic        load_done,
	input wire logic [3:0]  load_sel,
	input wire logic [15:0] load_count
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	a_pwr_gate: assert property (sect_pwr_en != 4'h0 |-> powered || $past(powered))
		else $error("section power without chip enable");
	a_done_pulse: assert property (load_done |=> !load_done)
		else $error("load_done longer than one cycle");
	a_req_sel_zero: assert property (relock_req |-> load_done && load_sel == 4'h0 && powered)
		else $error("relock request without register zero load");
	a_req_clears_pend: assert property (relock_req |=> !relock_pending)
		else $error("relock pending not cleared");
	a_count_step: assert property (load_done |-> load_count == $past(load_count) + 16'h0001)
		else $error("load count not stepped");
	a_idle_stable: assert property (!load_done |-> $stable(load_count) && $stable(load_sel))
		else $error("load status changed without load");
	a_strobe_done: assert property ($rose(latch_load_strobe) |-> ##[4:9] load_done)
		else $error("no load_done after strobe");
	a_done_cause: assert property (load_done |-> $past(latch_load_strobe, 3))
		else $error("load_done without strobe");
	a_pend_set: assert property ($rose(powered) |-> relock_pending)
		else $error("relock pending not set on power up");
endmodule

// ### tb/twp_host.sv
`timescale 1ns/1ps
// ==========================================================
// Controller on the serial lines
module twp_host (
	input  wire logic clk_sys,
	output logic      prog_clk,
	output logic      prog_data,
	output logic      latch_load_strobe
);
	initial begin
		prog_clk = 1'b0;
		prog_data = 1'b0;
		latch_load_strobe = 1'b0;
	end

	// Serial clock runs only inside a frame
	task automatic shift(input logic [23:0] w, input int n);
		#40;
		for (int i = n - 1; i >= 0; i--) begin
			prog_data = w[i];
			#62.5 prog_clk = 1'b1;
			#62.5 prog_clk = 1'b0;
		end
		prog_data = ~prog_data;
	endtask

	// Raised only once the word is complete
	task automatic strobe(input logic v);
		@(negedge clk_sys) latch_load_strobe = v;
	endtask
endmodule
